//--- verilog/mvf_cfg.svh
/*
  Offsets, field codes, reset values and counts of the measurement filter.
  Assumes a 250 MHz aclk and 24-bit measurement samples.
*/
`ifndef MVF_CFG_SVH
`define MVF_CFG_SVH
`define MVF_A_CTRL 8'h00
`define MVF_A_AVGN 8'h04
`define MVF_A_HOLD 8'h08
`define MVF_A_SPK 8'h0C
`define MVF_A_TOL 8'h10
`define MVF_A_BAUD 8'h14
`define MVF_A_CMD 8'h18
`define MVF_A_STAT 8'h1C
`define MVF_A_OUT 8'h20
`define MVF_A_MIN 8'h24
`define MVF_A_MAX 8'h28
`define MVF_A_P2P 8'h2C
`define MVF_AVG_NONE 2'h0
`define MVF_AVG_MOV 2'h1
`define MVF_AVG_REC 2'h2
`define MVF_AVG_MED 2'h3
`define MVF_DEF_MODE 2'h3
`define MVF_DEF_N 16'h0009
`define MVF_MOV_KMAX 3'h7
`define MVF_REC_NMAX 16'h8000
`define MVF_MED_MIN 16'h0003
`define MVF_MED_MAX 16'h0009
`define MVF_HOLD_MAX 11'h400
`define MVF_SPK_LMAX 4'hA
`define MVF_SPK_CMAX 7'h64
`define MVF_STAT_KMIN 4'h1
`define MVF_STAT_KMAX 4'hE
`define MVF_BAUD_DEF 16'h087A
`define MVF_ERR_VAL 24'h7FFFFF
`define MVF_LOSS_VAL 24'h7FFFFE
`define MVF_PAD 24'hFFFFFF
`define MVF_TX_LASTBIT 4'hA
`define MVF_TX_LASTBYTE 2'h2
`define MVF_DIV_STEPS 6'h28
`define MVF_RESP_OK 2'h0
`define MVF_RESP_ERR 2'h2
`endif

//--- verilog/mvf_pkg.sv
/*
  Types shared by the measurement filter and its serial sender.
  Assumes the constants of mvf_cfg.svh.
*/
package mvf_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_SPKW, S_AVG, S_DIVW, S_SORT, S_OUT
  } mvf_state_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [15:0] n;
  } mvf_nvcfg_t;
  typedef struct packed {
    logic [23:0] min;
    logic [23:0] max;
    logic [23:0] p2p;
  } mvf_stat_t;
endpackage : mvf_pkg

//--- verilog/mvf_uart_tx.sv
/*
  Serial sender: one 24-bit value as three 11-bit characters, high byte
  first, each start bit, eight data bits LSB first, even parity, stop bit.
  Assumes send is a one-cycle pulse taken only while busy is low.
*/
`timescale 1ns/100ps
`include "mvf_cfg.svh"
module mvf_uart_tx
  import mvf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] bit_div,
  input wire logic send,
  input wire logic [23:0] data,
  output logic busy,
  output logic txd
);
  logic [15:0] baud_r;
  logic [10:0] sh_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [23:0] data_r;
  logic busy_r;
  wire tick = busy_r && (baud_r == 16'h0000);
  wire [15:0] reload = (bit_div == 16'h0000) ? 16'h0000 : bit_div - 16'h0001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_r <= 16'h0000;
      sh_r <= 11'h7FF;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      data_r <= 24'h000000;
      busy_r <= 1'b0;
    end else if (send && !busy_r) begin
      sh_r <= {1'b1, ^data[23:16], data[23:16], 1'b0};
      data_r <= {data[15:0], 8'h00};
      busy_r <= 1'b1;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      baud_r <= reload;
    end else if (busy_r) begin
      baud_r <= tick ? reload : baud_r - 16'h0001;
      if (tick && bit_r == `MVF_TX_LASTBIT) begin
        bit_r <= 4'h0;
        if (byte_r == `MVF_TX_LASTBYTE) begin
          busy_r <= 1'b0;
          sh_r <= 11'h7FF;
        end else begin
          byte_r <= byte_r + 2'h1;
          sh_r <= {1'b1, ^data_r[23:16], data_r[23:16], 1'b0};
          data_r <= {data_r[15:0], 8'h00};
        end
      end else if (tick) begin
        bit_r <= bit_r + 4'h1;
        sh_r <= {1'b1, sh_r[10:1]};
      end
    end
  end

  assign busy = busy_r;
  assign txd = sh_r[0];
endmodule : mvf_uart_tx

//--- verilog/mvf_filter.sv
/*
  Measurement value filter: video curve averaging, spike correction,
  moving/recursive/median averaging, error hold, statistics, serial out.
  Assumes an AXI4-Lite master, samples from the distance stage on aclk,
  and an outside store that saves nv_cfg_out on nv_store.
*/
// What this block does
// - Video curves averaged pixel by pixel before distance calculation.
// - Measurement averaging sits after distance calculation, before output.
// - Moving mode outputs the mean of the newest N values, N rounded down to a power of two.
// - Moving window is a power of two, at most 128.
// - Recursive: (new + (N-1) * previous) / N, N up to 32768.
// - Median of newest 3, 5, 7 or 9 values, or of all values held while fewer are stored.
// - Reset defaults to median over nine values.
// - Mode and window are handed to non-volatile storage.
// - Average recomputed after every valid measurement.
// - Exactly one output value per measurement accepted while idle; one arriving while busy gets none.
// - Error mode outputs an error value for invalid measurements.
// - Hold mode repeats last valid value up to 0..1024 times.
// - Hold count zero repeats the last valid value forever.
// - Spike settings: length 1-10, tolerance, count 1-100.
// - Min, max and peak-to-peak over 2^k values.
// - Each value is sent as three 11-bit characters.
// - Outliers beyond tolerance of the mean replaced by previous value.
// - Statistics reset starts a new cycle, discarding old results.
// - Lost values are flagged by an error code in the next record.
`timescale 1ns/100ps
`include "mvf_cfg.svh"
module mvf_filter
  import mvf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_valid,
  input wire logic pix_last,
  input wire logic [7:0] pix_idx,
  input wire logic [11:0] pix_val,
  output logic vid_valid,
  output logic [11:0] vid_val,
  input wire logic meas_valid,
  input wire logic meas_ok,
  input wire logic [23:0] sample_value,
  output logic out_valid,
  output logic [23:0] out_value,
  input wire logic nv_load,
  input wire mvf_nvcfg_t nv_cfg_in,
  output logic nv_store,
  output mvf_nvcfg_t nv_cfg_out,
  output logic txd
);
  logic [1:0] mode_r;
  logic [15:0] avg_n_r;
  logic hold_mode_r, spk_en_r, cfg_clr_r, nv_store_r, stat_clr_r, lost_r;
  logic [2:0] vid_mode_r;
  logic [3:0] stat_k_r, spk_len_r;
  logic [10:0] hold_n_r, hold_cnt_r;
  logic [6:0] spk_max_r, corr_r;
  logic [23:0] spk_tol_r, x_r, xs_r, y_r, last_r, out_value_r;
  logic [15:0] baud_r;
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r, ok_r, have_last_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r, wd;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  mvf_state_t st_r;
  mvf_stat_t stat_r;
  logic [23:0] st_min_r, st_max_r;
  logic [14:0] st_cnt_r;
  logic [39:0] div_q_r;
  logic [16:0] div_rem_r;
  logic [15:0] div_den_r;
  logic [5:0] div_cnt_r;
  logic div_busy_r, out_valid_r, tx_busy;
  logic [23:0] mv_mem [0:127];
  logic [6:0] mv_ptr_r;
  logic [7:0] mv_have_r;
  logic [30:0] mv_sum_r;
  logic rec_have_r;
  logic [23:0] rec_prev_r;
  logic [23:0] md_r [0:8];
  logic [23:0] md_in [0:8];
  logic [23:0] srt_r [0:8];
  logic [23:0] srt_nxt [0:8];
  logic [3:0] md_have_r, pass_r;
  logic [23:0] sh_r [0:9];
  logic [23:0] sh_in [0:9];
  logic [3:0] sh_have_r;
  logic [27:0] spk_sum;
  logic [11:0] vh0 [0:255];
  logic [11:0] vh1 [0:255];
  logic [11:0] vh2 [0:255];
  logic [1:0] vcnt_r;
  logic [11:0] vid_val_r, vout;
  logic vid_valid_r;

  function automatic logic [32:0] view(input logic [7:0] a);
    case (a)
      `MVF_A_CTRL: view = {1'b1, 20'h0, stat_k_r, 1'b0, vid_mode_r, spk_en_r,
                           hold_mode_r, mode_r};
      `MVF_A_AVGN: view = {1'b1, 16'h0, avg_n_r};
      `MVF_A_HOLD: view = {1'b1, 21'h0, hold_n_r};
      `MVF_A_SPK: view = {1'b1, 17'h0, spk_max_r, 4'h0, spk_len_r};
      `MVF_A_TOL: view = {1'b1, 8'h0, spk_tol_r};
      `MVF_A_BAUD: view = {1'b1, 16'h0, baud_r};
      `MVF_A_CMD: view = {1'b1, 32'h0};
      `MVF_A_STAT: view = {1'b1, 29'h0, lost_r, tx_busy, st_r != S_IDLE};
      `MVF_A_OUT: view = {1'b1, 8'h0, out_value_r};
      `MVF_A_MIN: view = {1'b1, 8'h0, stat_r.min};
      `MVF_A_MAX: view = {1'b1, 8'h0, stat_r.max};
      `MVF_A_P2P: view = {1'b1, 8'h0, stat_r.p2p};
      default: view = {1'b0, 32'h0};
    endcase
  endfunction : view

  // AXI4-Lite slave: address and data taken in either order.
  wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
  logic [32:0] wr_old, rd_word;
  always_comb begin
    wr_old = view(aw_addr_r);
    rd_word = view(s_axi_araddr);
  end
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wd[8*gi +: 8] = w_strb_r[gi] ? w_data_r[8*gi +: 8]
                                          : wr_old[8*gi +: 8];
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bresp_r <= `MVF_RESP_OK;
      rresp_r <= `MVF_RESP_OK;
      rdata_r <= 32'h0;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) aw_have_r <= 1'b0;
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) w_have_r <= 1'b0;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_old[32] ? `MVF_RESP_OK : `MVF_RESP_ERR;
      end else if (s_axi_bready) bvalid_r <= 1'b0;
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_word[31:0];
        rresp_r <= rd_word[32] ? `MVF_RESP_OK : `MVF_RESP_ERR;
      end else if (s_axi_rready) rvalid_r <= 1'b0;
    end
  end

  // Configuration; a changed mode or window clears history next cycle.
  wire ctrl_wr = wr_fire && aw_addr_r == `MVF_A_CTRL;
  wire avgn_wr = wr_fire && aw_addr_r == `MVF_A_AVGN;
  wire cfg_chg = (ctrl_wr && (wd[1:0] != mode_r || wd[6:4] != vid_mode_r))
                 || (avgn_wr && wd[15:0] != avg_n_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= `MVF_DEF_MODE;
      avg_n_r <= `MVF_DEF_N;
      {hold_mode_r, spk_en_r, cfg_clr_r, nv_store_r, stat_clr_r} <= 5'h00;
      vid_mode_r <= 3'h0;
      stat_k_r <= `MVF_STAT_KMIN;
      hold_n_r <= 11'h000;
      spk_len_r <= 4'h1;
      spk_max_r <= 7'h01;
      spk_tol_r <= 24'h000000;
      baud_r <= `MVF_BAUD_DEF;
    end else begin
      cfg_clr_r <= nv_load || cfg_chg;
      nv_store_r <= cfg_chg && !nv_load;
      stat_clr_r <= wr_fire && aw_addr_r == `MVF_A_CMD && wd[0];
      if (nv_load) begin
        mode_r <= nv_cfg_in.mode;
        avg_n_r <= nv_cfg_in.n;
      end else if (wr_fire) begin
        case (aw_addr_r)
          `MVF_A_CTRL: begin
            {vid_mode_r, spk_en_r, hold_mode_r, mode_r} <= wd[6:0];
            stat_k_r <= (wd[11:8] < `MVF_STAT_KMIN) ? `MVF_STAT_KMIN :
                        (wd[11:8] > `MVF_STAT_KMAX) ? `MVF_STAT_KMAX
                                                    : wd[11:8];
          end
          `MVF_A_AVGN: avg_n_r <= wd[15:0];
          `MVF_A_HOLD: hold_n_r <= (wd[10:0] > `MVF_HOLD_MAX) ?
                                   `MVF_HOLD_MAX : wd[10:0];
          `MVF_A_SPK: begin
            spk_len_r <= (wd[3:0] == 4'h0) ? 4'h1 : (wd[3:0] > `MVF_SPK_LMAX)
                         ? `MVF_SPK_LMAX : wd[3:0];
            spk_max_r <= (wd[14:8] == 7'h00) ? 7'h01 : (wd[14:8] >
                         `MVF_SPK_CMAX) ? `MVF_SPK_CMAX : wd[14:8];
          end
          `MVF_A_TOL: spk_tol_r <= wd[23:0];
          `MVF_A_BAUD: baud_r <= wd[15:0];
          default: ;
        endcase
      end
    end
  end

  // Effective windows after legalising N for each mode.
  logic [2:0] mov_k;
  always_comb begin
    mov_k = 3'h0;
    for (int i = 1; i < 8; i++) if (avg_n_r[i]) mov_k = 3'(i);
    if (avg_n_r[15:8] != 8'h00) mov_k = `MVF_MOV_KMAX;
  end
  wire [15:0] rec_n = (avg_n_r == 16'h0) ? 16'h1 : (avg_n_r > `MVF_REC_NMAX)
                      ? `MVF_REC_NMAX : avg_n_r;
  wire [15:0] med_n16 = (avg_n_r < `MVF_MED_MIN) ? `MVF_MED_MIN :
                        (avg_n_r > `MVF_MED_MAX) ? `MVF_MED_MAX
                                                 : (avg_n_r | 16'h1);
  wire [3:0] med_n = med_n16[3:0];
  wire [7:0] mv_win = 8'h01 << mov_k;
  wire mv_full = mv_have_r == mv_win;
  wire [23:0] mv_old = mv_mem[7'(mv_ptr_r - mv_win[6:0])];
  wire [30:0] mv_sum_nxt = mv_sum_r + 31'(xs_r) - (mv_full ? 31'(mv_old)
                                                           : 31'h0);
  wire [7:0] mv_have_nxt = mv_full ? mv_have_r : mv_have_r + 8'h1;
  wire [39:0] rec_num = 40'(xs_r) + 40'(rec_n - 16'h1) * 40'(rec_prev_r);
  wire [3:0] md_have_nxt = (md_have_r >= med_n) ? med_n
                                                : md_have_r + 4'h1;
  wire [3:0] spk_n = (sh_have_r < spk_len_r) ? sh_have_r : spk_len_r;
  always_comb begin
    spk_sum = 28'h0;
    for (int i = 0; i < 10; i++)
      if (4'(i) < spk_n) spk_sum = spk_sum + 28'(sh_r[i]);
  end

  // One shared serial divider serves spike mean, moving and recursive.
  wire start_meas = st_r == S_IDLE && meas_valid;
  wire spk_go = start_meas && meas_ok && spk_en_r && sh_have_r != 4'h0;
  wire avg_go = st_r == S_AVG && (mode_r == `MVF_AVG_MOV ||
                                  (mode_r == `MVF_AVG_REC && rec_have_r));
  wire [39:0] div_num = spk_go ? 40'(spk_sum) : (mode_r == `MVF_AVG_MOV)
                        ? 40'(mv_sum_nxt) : rec_num;
  wire [15:0] div_den = spk_go ? 16'(spk_n) : (mode_r == `MVF_AVG_MOV)
                        ? 16'(mv_have_nxt) : rec_n;
  wire div_done = div_busy_r && div_cnt_r == 6'h0;
  wire [16:0] div_t = {div_rem_r[15:0], div_q_r[39]};
  wire div_ge = div_t >= {1'b0, div_den_r};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {div_q_r, div_rem_r, div_den_r} <= 73'h0;
      div_cnt_r <= 6'h0;
      div_busy_r <= 1'b0;
    end else if (spk_go || avg_go) begin
      {div_q_r, div_rem_r, div_den_r} <= {div_num, 17'h0, div_den};
      div_cnt_r <= `MVF_DIV_STEPS;
      div_busy_r <= 1'b1;
    end else if (div_done) div_busy_r <= 1'b0;
    else if (div_busy_r) begin
      div_rem_r <= div_ge ? div_t - {1'b0, div_den_r} : div_t;
      div_q_r <= {div_q_r[38:0], div_ge};
      div_cnt_r <= div_cnt_r - 6'h1;
    end
  end

  // Shift histories for median and spike windows, and the sort array.
  wire md_push = st_r == S_AVG && mode_r == `MVF_AVG_MED;
  wire sh_push = st_r == S_AVG && spk_en_r;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_hist
      if (gi == 0) begin : g_first
        assign sh_in[gi] = xs_r;
      end else begin : g_rest
        assign sh_in[gi] = sh_r[gi-1];
      end
      always_ff @(posedge aclk) if (sh_push) sh_r[gi] <= sh_in[gi];
      if (gi < 9) begin : g_med
        assign md_in[gi] = (gi == 0) ? xs_r : md_r[(gi == 0) ? 0 : gi-1];
        assign srt_nxt[gi] = (gi < 8 && gi % 2 == pass_r[0] &&
                              srt_r[gi] > srt_r[(gi + 1) % 9]) ?
                             srt_r[(gi + 1) % 9] : (gi > 0 && (gi - 1) % 2 ==
                             pass_r[0] && srt_r[(gi + 8) % 9] > srt_r[gi])
                             ? srt_r[(gi + 8) % 9] : srt_r[gi];
        always_ff @(posedge aclk) begin
          if (md_push) begin
            md_r[gi] <= md_in[gi];
            srt_r[gi] <= (4'(gi) < md_have_nxt) ? md_in[gi] : `MVF_PAD;
          end else if (st_r == S_SORT) srt_r[gi] <= srt_nxt[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk)
    if (st_r == S_AVG && mode_r == `MVF_AVG_MOV) mv_mem[mv_ptr_r] <= xs_r;

  // Per-measurement sequence; a sample arriving while busy is ignored.
  wire [23:0] spk_mean = div_q_r[23:0];
  wire [23:0] spk_dev = (x_r > spk_mean) ? x_r - spk_mean : spk_mean - x_r;
  wire spiky = spk_dev > spk_tol_r && corr_r < spk_max_r;
  wire can_hold = hold_mode_r && have_last_r &&
                  (hold_n_r == 11'h0 || hold_cnt_r < hold_n_r);
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_clr_r) begin
      mv_ptr_r <= 7'h0;
      mv_have_r <= 8'h0;
      mv_sum_r <= 31'h0;
      rec_have_r <= 1'b0;
      md_have_r <= 4'h0;
    end else if (st_r == S_AVG && mode_r == `MVF_AVG_MOV) begin
      mv_ptr_r <= mv_ptr_r + 7'h1;
      mv_have_r <= mv_have_nxt;
      mv_sum_r <= mv_sum_nxt;
    end else if (md_push) md_have_r <= md_have_nxt;
    else if (st_r == S_OUT && ok_r && mode_r == `MVF_AVG_REC)
      rec_have_r <= 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= S_IDLE;
      {x_r, xs_r, y_r, last_r, out_value_r, rec_prev_r} <= 144'h0;
      {ok_r, have_last_r, out_valid_r} <= 3'h0;
      {hold_cnt_r, corr_r, sh_have_r, pass_r} <= 26'h0;
    end else begin
      out_valid_r <= 1'b0;
      unique case (st_r)
        S_IDLE: if (meas_valid) begin
          x_r <= sample_value;
          xs_r <= sample_value;
          ok_r <= meas_ok;
          st_r <= !meas_ok ? S_OUT : spk_go ? S_SPKW : S_AVG;
        end
        S_SPKW: if (div_done) begin
          xs_r <= spiky ? sh_r[0] : x_r;
          corr_r <= spiky ? corr_r + 7'h1 : 7'h0;
          st_r <= S_AVG;
        end
        S_AVG: begin
          if (spk_en_r && sh_have_r < `MVF_SPK_LMAX)
            sh_have_r <= sh_have_r + 4'h1;
          pass_r <= 4'h0;
          y_r <= xs_r;
          if (mode_r == `MVF_AVG_REC && !rec_have_r) rec_prev_r <= xs_r;
          st_r <= avg_go ? S_DIVW : md_push ? S_SORT : S_OUT;
        end
        S_DIVW: if (div_done) begin
          y_r <= div_q_r[23:0];
          rec_prev_r <= div_q_r[23:0];
          st_r <= S_OUT;
        end
        S_SORT: begin
          pass_r <= pass_r + 4'h1;
          if (pass_r == 4'h9) begin
            y_r <= srt_r[md_have_r >> 1];
            st_r <= S_OUT;
          end
        end
        S_OUT: begin
          out_valid_r <= 1'b1;
          st_r <= S_IDLE;
          if (ok_r) begin
            out_value_r <= y_r;
            last_r <= y_r;
            have_last_r <= 1'b1;
            hold_cnt_r <= 11'h0;
          end else if (can_hold) begin
            out_value_r <= last_r;
            if (hold_n_r != 11'h0) hold_cnt_r <= hold_cnt_r + 11'h1;
          end else out_value_r <= `MVF_ERR_VAL;
        end
      endcase
    end
  end

  // Statistics over 2^k valid outputs; results latch at cycle end.
  wire st_go = st_r == S_OUT && ok_r;
  wire [23:0] nmin = (st_cnt_r == 15'h0 || y_r < st_min_r) ? y_r : st_min_r;
  wire [23:0] nmax = (st_cnt_r == 15'h0 || y_r > st_max_r) ? y_r : st_max_r;
  wire st_end = (st_cnt_r + 15'h1) == (15'h1 << stat_k_r);
  always_ff @(posedge aclk) begin
    if (!aresetn || stat_clr_r) begin
      st_cnt_r <= 15'h0;
      {st_min_r, st_max_r} <= 48'h0;
      stat_r <= '0;
    end else if (st_go) begin
      st_min_r <= nmin;
      st_max_r <= nmax;
      st_cnt_r <= st_end ? 15'h0 : st_cnt_r + 15'h1;
      if (st_end) stat_r <= '{nmin, nmax, nmax - nmin};
    end
  end

  // Video curve averaging, one output pixel per input pixel.
  wire [11:0] p0 = vh0[pix_idx];
  wire [11:0] p1 = vh1[pix_idx];
  wire [11:0] p2 = vh2[pix_idx];
  wire [1:0] vk = vid_mode_r[1:0];
  wire [15:0] vrec = (16'(pix_val) + (16'(p0) << vk) - 16'(p0)) >> vk;
  wire [1:0] vm = vid_mode_r[1:0] - 2'h3;
  wire [1:0] va = (vcnt_r < vm) ? vcnt_r : vm;
  wire [15:0] vsum = 16'(pix_val) + 16'(p0) + ((va >= 2'h2) ? 16'(p1) : 16'h0)
                     + ((va == 2'h3) ? 16'(p2) : 16'h0);
  wire [31:0] v3 = 32'(vsum) * 32'h0000AAAB;
  wire [11:0] lo = (pix_val < p0) ? pix_val : p0;
  wire [11:0] hi = (pix_val < p0) ? p0 : pix_val;
  wire [11:0] v_med = (hi < p1) ? hi : (lo > p1) ? lo : p1;
  always_comb begin
    vout = pix_val;
    if (vcnt_r != 2'h0) begin
      case (vid_mode_r)
        3'h1, 3'h2, 3'h3: vout = vrec[11:0];
        3'h4, 3'h5, 3'h6: vout = (va == 2'h1) ? vsum[12:1] : (va == 2'h2) ?
                          v3[28:17] : vsum[13:2];
        3'h7: vout = (vcnt_r >= 2'h2) ? v_med : pix_val;
        default: vout = pix_val;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (pix_valid) begin
      vh0[pix_idx] <= vid_mode_r[2] ? pix_val : vout;
      vh1[pix_idx] <= p0;
      vh2[pix_idx] <= p1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_clr_r) vcnt_r <= 2'h0;
    else if (pix_valid && pix_last && vcnt_r != 2'h3) vcnt_r <= vcnt_r + 2'h1;
    vid_valid_r <= aresetn && pix_valid;
    vid_val_r <= pix_valid ? vout : vid_val_r;
  end

  // Serial output; a value that finds the sender busy is dropped.
  wire tx_send = out_valid_r && !tx_busy;
  always_ff @(posedge aclk) begin
    if (!aresetn) lost_r <= 1'b0;
    else if (out_valid_r && tx_busy) lost_r <= 1'b1;
    else if (tx_send) lost_r <= 1'b0;
  end
  mvf_uart_tx u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .bit_div(baud_r),
    .send(tx_send),
    .data(lost_r ? `MVF_LOSS_VAL : out_value_r),
    .busy(tx_busy),
    .txd(txd)
  );

  assign {s_axi_awready, s_axi_wready} = {!aw_have_r, !w_have_r};
  assign {s_axi_bvalid, s_axi_bresp} = {bvalid_r, bresp_r};
  assign {s_axi_arready, s_axi_rvalid} = {!rvalid_r, rvalid_r};
  assign {s_axi_rdata, s_axi_rresp} = {rdata_r, rresp_r};
  assign {vid_valid, vid_val} = {vid_valid_r, vid_val_r};
  assign {out_valid, out_value} = {out_valid_r, out_value_r};
  assign nv_store = nv_store_r;
  assign nv_cfg_out = '{mode_r, avg_n_r};
endmodule : mvf_filter

//--- verification/mvf_filter_chk.sv
/* Port checker of mvf_filter; assumes the bind that follows it. */
`timescale 1ns/100ps
module mvf_chk (
  input wire logic aclk, aresetn, meas_valid, out_valid, nv_store, txd,
  input wire logic pix_valid, vid_valid, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_rvalid, s_axi_rready, s_axi_arvalid, s_axi_arready,
  input wire logic [23:0] out_value
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  out_pulse_a: assert property (out_valid |=> !out_valid)
    else $error("out_valid too long");
  meas_answer_a: assert property (meas_valid |-> ##[2:120] out_valid)
    else $error("no output");
  out_hold_a: assert property (!out_valid |-> $stable(out_value))
    else $error("out_value moved");
  vid_lat_a: assert property (vid_valid == $past(pix_valid))
    else $error("vid_valid late");
  tx_idle_a: assert property ($rose(aresetn) |-> txd)
    else $error("txd not idle");
  nv_pulse_a: assert property (nv_store |=> !nv_store)
    else $error("nv_store too long");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no rvalid");
  cover property (out_valid);
  cover property (nv_store);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : mvf_chk
bind mvf_filter mvf_chk chk_u (.*);

//--- verification/mvf_host_rx.sv
/* Host serial receiver; assumes BITC clocks per bit, as programmed. */
`timescale 1ns/100ps
module mvf_host_rx #(parameter int BITC = 8) (
  input wire logic aclk,
  input wire logic txd,
  output logic [23:0] rx_word,
  output int rx_bad
);
  initial begin
    logic [10:0] f;
    rx_bad = 0;
    forever begin
      @(negedge txd);
      for (int i = 0; i < 11; i++) begin
        repeat (i ? BITC : BITC / 2) @(posedge aclk);
        f[i] = txd;
      end
      if (f[0] || !f[10] || ^f[9:1]) rx_bad++;
      rx_word = {rx_word[15:0], f[8:1]};
    end
  end
endmodule : mvf_host_rx

//--- verification/tb_top.sv
/* Bench of mvf_filter and host model; assumes the checker is bound in. */
`timescale 1ns/100ps
module tb_top
  import mvf_pkg::*;
;
  logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic pix_valid = '0, pix_last = '0, meas_valid = '0, meas_ok = '0;
  logic nv_load = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, txd;
  logic s_axi_arready, s_axi_rvalid, vid_valid, out_valid, nv_store;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, pix_idx = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [11:0] pix_val = '0, vid_val;
  logic [23:0] sample_value = '0, out_value, rxw;
  mvf_nvcfg_t nv_cfg_in = '0, nv_cfg_out;
  int fail_count = 0, cmp_count = 0, rxb;
  mvf_filter dut_u (.*);
  mvf_host_rx #(.BITC(8)) host_u (.aclk, .txd, .rx_word(rxw), .rx_bad(rxb));
  initial forever #2 aclk = ~aclk;
  task automatic chk(input string s, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic complete_run(input bit t);
    fail_count += t;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // Starts one edge late so that ready lines are never set twice at once.
  task automatic ax(input bit w, input logic [7:0] a,
      input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (int n = 0; n < 99; n++) begin
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      if (s_axi_bvalid || s_axi_rvalid) break;
      if (n == 98) complete_run(1);
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (!w) chk("rdata", d, s_axi_rdata);
    chk("resp", r, w ? s_axi_bresp : s_axi_rresp);
  endtask : ax
  // The wait after the output covers one whole record on the line.
  task automatic ms(input bit ok, k, input logic [23:0] v, e);
    meas_valid <= 1'b1;
    meas_ok <= ok;
    sample_value <= v;
    @(posedge aclk);
    meas_valid <= 1'b0;
    for (int n = 0; !out_valid; n++) begin
      @(posedge aclk);
      if (n == 150) complete_run(1);
    end
    repeat (280) @(posedge aclk);
    if (k) chk("out_value", e, out_value);
    if (k) chk("serial", e, rxw);
  endtask : ms
  task automatic avg(input logic [31:0] c, n, input logic [23:0] v[5], x[5],
      input int s);
    ax(1, 8'h00, c, 2'h0);
    ax(1, 8'h04, n, 2'h0);
    chk("nv_cfg", {c[1:0], n[15:0]}, nv_cfg_out);
    foreach (v[i]) ms(1, i >= s, v[i], x[i]);
  endtask : avg
  task automatic t_reset;
    ax(0, 8'h00, 32'h00000103, 2'h0);
    ax(0, 8'h04, 32'h00000009, 2'h0);
    chk("nv_cfg", 32'h00030009, nv_cfg_out);
    ax(0, 8'hFC, 32'h00000000, 2'h2);
    ax(1, 8'h14, 32'h00000008, 2'h0);
    pix_valid <= 1'b1;
    pix_val <= 12'hABC;
    @(posedge aclk);
    pix_valid <= 1'b0;
    @(posedge aclk);
    chk("vid_val", 32'h00000ABC, vid_val);
    ax(1, 8'h00, 32'h40, 2'h0);
    pix_last <= 1'b1;
    for (int i = 1; i < 5; i++) begin
      pix_valid <= i < 4;
      pix_val <= 12'(i * 256);
      @(posedge aclk);
    end
    chk("vid", 32'h280, vid_val);
    $display("reset test done");
  endtask : t_reset
  task automatic t_avg;
    avg(32'h3, 32'h3, '{5, 1, 3, 9, 8}, '{0, 0, 3, 3, 8}, 2);
    avg(32'h1, 32'h4, '{4, 8, 12, 16, 20}, '{0, 0, 0, 10, 14}, 3);
    avg(32'h2, 32'h2, '{0, 200, 300, 400, 300}, '{0, 100, 200, 300, 300},
        0);
    $display("averaging test done");
  endtask : t_avg
  task automatic t_err;
    ax(1, 8'h00, 32'h0, 2'h0);
    ms(1, 1, 24'h32, 24'h32);
    ms(0, 1, 24'h0, 24'h7FFFFF);
    ax(1, 8'h00, 32'h4, 2'h0);
    ax(1, 8'h08, 32'h1, 2'h0);
    ms(1, 1, 24'h32, 24'h32);
    ms(0, 1, 24'h0, 24'h32);
    ms(0, 1, 24'h0, 24'h7FFFFF);
    ax(1, 8'h08, 32'h0, 2'h0);
    ms(0, 1, 24'h0, 24'h32);
    ms(0, 1, 24'h0, 24'h32);
    ax(1, 8'h00, 32'h8, 2'h0);
    ms(1, 1, 24'h10, 24'h10);
    ms(1, 1, 24'h40, 24'h10);
    ms(1, 1, 24'h40, 24'h40);
    $display("error test done");
  endtask : t_err
  task automatic t_stat;
    ax(1, 8'h00, 32'h100, 2'h0);
    ax(1, 8'h18, 32'h1, 2'h0);
    ms(1, 1, 24'h10, 24'h10);
    ms(1, 1, 24'h30, 24'h30);
    ax(0, 8'h24, 32'h10, 2'h0);
    ax(0, 8'h2C, 32'h20, 2'h0);
    ax(1, 8'h18, 32'h1, 2'h0);
    ax(0, 8'h28, 32'h0, 2'h0);
    chk("line", 32'h0, rxb);
    $display("statistics test done");
  endtask : t_stat
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_avg();
    t_err();
    t_stat();
    complete_run(0);
  end
endmodule : tb_top
